/* bench/rca_arbiter_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module rca_arbiter_sva #(
  parameter int NUM_IF = 4,
  parameter int IF_W   = 2
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // bus handshake
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  // panel and analog pins
  input wire logic              remote_sel_n_i,
  input wire logic              standby_input_i,
  input wire logic              panel_off_i,
  // digital interfaces
  input wire logic [NUM_IF-1:0] dig_req_i,
  input wire logic [NUM_IF-1:0] dig_query_i,
  input wire logic [NUM_IF-1:0] dig_grant_o,
  input wire logic [NUM_IF-1:0] dig_err_o,
  input wire logic [NUM_IF-1:0] dig_query_ack_o,
  // location and power
  input wire logic [3:0]        location_o,
  input wire logic [IF_W-1:0]   owner_o,
  input wire logic              power_input_en_o,
  input wire logic              sup_timeout_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // location steps
  sequence s_in_digital;
    location_o == 4'h4;
  endsequence
  sequence s_analog_claim;
    !remote_sel_n_i && (location_o == 4'h1) && (dig_req_i == '0);
  endsequence

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_one_location: assert property ($onehot(location_o) && $onehot0(dig_grant_o))
    else $error("more than one control location");
  a_analog_refuse: assert property (
    !remote_sel_n_i && (location_o[1:0] != 2'h0) && (|dig_req_i)
    |=> dig_err_o == $past(dig_req_i))
    else $error("digital request not refused under analog select");
  a_digital_keeps: assert property (s_in_digital |=> location_o != 4'h2)
    else $error("analog took over from digital");
  a_query_answer: assert property ((|dig_query_i) |=> dig_query_ack_o == $past(dig_query_i))
    else $error("status query not answered");
  a_grant_owner: assert property (
    (|dig_grant_o) |-> location_o == 4'h4 && dig_grant_o == (4'h1 << owner_o))
    else $error("grant without matching owner");
  a_timeout_exit: assert property (
    sup_timeout_o |-> location_o == 4'h1 && $past(location_o) == 4'h4)
    else $error("timeout exit wrong");
  a_panel_off: assert property (panel_off_i |=> !power_input_en_o)
    else $error("panel off not honoured");
  a_standby_off: assert property (standby_input_i |=> !power_input_en_o)
    else $error("standby did not switch power off");
  a_analog_take: assert property (s_analog_claim |=> location_o == 4'h2)
    else $error("analog select low not taken");
endmodule

bind rca_arbiter rca_arbiter_sva #(.NUM_IF(NUM_IF), .IF_W(IF_W)) u_sva (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .remote_sel_n_i, .standby_input_i,
  .panel_off_i, .dig_req_i, .dig_query_i, .dig_grant_o, .dig_err_o, .dig_query_ack_o,
  .location_o, .owner_o, .power_input_en_o, .sup_timeout_o);

`default_nettype wire

/* bench/rca_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

module rca_ctrl_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // keep-alive setup
  input  wire logic       en_i,
  input  wire logic [1:0] idx_i,
  input  wire logic [7:0] gap_i,
  // messages towards the block
  output logic      [3:0] msg_o
);
  logic [7:0] cnt_reg;

  // one message per gap on the owning interface while enabled
  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_reg <= 8'h00;
      msg_o   <= 4'h0;
    end else begin
      cnt_reg <= (cnt_reg == gap_i) ? 8'h00 : cnt_reg + 8'h01;
      msg_o   <= (cnt_reg == gap_i) ? (4'h1 << idx_i) : 4'h0;
    end
  end
endmodule

`default_nettype wire

/* bench/test_remote_control_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rca_consts.svh"

module test_remote_control_arbiter;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc   = 1'h0;
  logic        stb   = 1'h0;
  logic        we    = 1'h0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        sel_n = 1'h1;
  logic        stby  = 1'h0;
  logic        poff  = 1'h0;
  logic        pon   = 1'h0;
  logic        aon   = 1'h0;
  logic [3:0]  bsel  = 4'hF;
  logic        pm_en = 1'h0;
  logic [3:0]  req   = 4'h0;
  logic [3:0]  rel   = 4'h0;
  logic [3:0]  don   = 4'h0;
  logic [3:0]  qry   = 4'h0;
  logic [3:0]  msg, grant, err, qack, loc;
  logic [1:0]  own;
  logic        pwr, tmo;
  int          bad_count = 0;
  int          n_tests   = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  rca_arbiter #(.MS_CYCLES(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .remote_sel_n_i(sel_n), .analog_dc_on_i(aon), .standby_input_i(stby),
    .panel_on_i(pon), .panel_off_i(poff), .dig_req_i(req), .dig_rel_i(rel),
    .dig_msg_i(msg), .dig_dc_on_i(don), .dig_dc_off_i(4'h0), .dig_query_i(qry),
    .dig_grant_o(grant), .dig_err_o(err), .dig_query_ack_o(qack), .location_o(loc),
    .owner_o(own), .power_input_en_o(pwr), .sup_timeout_o(tmo));

  rca_ctrl_model u_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(pm_en), .idx_i(2'h1), .gap_i(8'h06), .msg_o(msg));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n == 20) bad_count++;
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask

  // one-cycle pulse on a digital or panel input, outputs sampled after
  task automatic dpulse(input int k, input logic [3:0] v);
    @(posedge clk_i);
    case (k)
      0: req <= v;
      1: rel <= v;
      2: don <= v;
      3: qry <= v;
      4: poff <= v[0];
      default: pon <= v[0];
    endcase
    @(posedge clk_i);
    pon  <= 1'h0;
    req  <= 4'h0;
    rel  <= 4'h0;
    don  <= 4'h0;
    qry  <= 4'h0;
    poff <= 1'h0;
    @(negedge clk_i);
  endtask

  task automatic settle;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #5000000;
    bad_count++;
    test_done();
  end

  // test sequence
  initial begin
    int n;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, `RCA_ADDR_CTRL, 32'h0);
    chk(q, 32'h3, "control reset");
    wb(1'h0, `RCA_ADDR_CUR, 32'h0);
    chk(q, {16'h0, `RCA_TMO_RST}, "active timeout reset");
    wb(1'h0, 8'h10, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'h1, `RCA_ADDR_TMO, 32'h3);
    wb(1'h0, `RCA_ADDR_CUR, 32'h0);
    chk(q, 32'h3, "timeout idle apply");
    bsel <= 4'h1;
    wb(1'h1, `RCA_ADDR_TMO, 32'h7);
    bsel <= 4'hF;
    wb(1'h0, `RCA_ADDR_CUR, 32'h0);
    chk(q, 32'h3, "partial select ignored");
    chk(loc, 4'h1, "manual at start");
    $display("test registers done");
    dpulse(0, 4'h2);
    chk({grant, loc, 2'h0, own}, 12'h241, "digital grant");
    @(posedge clk_i);
    pm_en <= 1'h1;
    sel_n <= 1'h0;
    settle();
    chk(loc, 4'h4, "analog ignored");
    dpulse(0, 4'h4);
    chk(err, 4'h4, "second owner refused");
    dpulse(3, 4'h8);
    chk(qack, 4'h8, "query answered");
    dpulse(2, 4'h2);
    chk(pwr, 1'h1, "power on");
    @(posedge clk_i);
    sel_n <= 1'h1;
    wb(1'h1, `RCA_ADDR_TMO, 32'h5);
    repeat (40) @(negedge clk_i);
    chk(loc, 4'h4, "kept alive");
    wb(1'h0, `RCA_ADDR_CUR, 32'h0);
    chk(q, 32'h3, "timeout still old");
    pm_en <= 1'h0;
    n = 0;
    while (tmo !== 1'h1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    chk({tmo, loc}, 5'h11, "timeout exit");
    chk(pwr, 1'h0, "power off after loss");
    wb(1'h0, `RCA_ADDR_CUR, 32'h0);
    chk(q, 32'h5, "timeout new value");
    $display("test digital done");
    @(posedge clk_i);
    sel_n <= 1'h0;
    settle();
    chk(loc, 4'h2, "analog taken");
    @(posedge clk_i);
    aon <= 1'h1;
    settle();
    chk(pwr, 1'h1, "analog power on");
    dpulse(0, 4'h1);
    chk(err, 4'h1, "digital refused");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h2);
    settle();
    chk(loc, 4'h8, "local over analog");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h3);
    settle();
    chk(loc, 4'h2, "analog restored");
    @(posedge clk_i);
    aon   <= 1'h0;
    sel_n <= 1'h1;
    settle();
    chk(loc, 4'h1, "analog released");
    $display("test analog done");
    dpulse(0, 4'h1);
    chk(loc, 4'h4, "digital again");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h2);
    settle();
    chk(loc, 4'h8, "local ends session");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h3);
    settle();
    chk(loc, 4'h1, "no resume");
    $display("test local done");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h1);
    dpulse(0, 4'h4);
    chk(grant, 4'h4, "grant without supervision");
    repeat (40) @(negedge clk_i);
    chk(loc, 4'h4, "no supervision exit");
    dpulse(2, 4'h4);
    dpulse(4, 4'h1);
    chk(pwr, 1'h0, "panel off");
    dpulse(2, 4'h4);
    @(posedge clk_i);
    stby <= 1'h1;
    settle();
    chk(pwr, 1'h0, "standby off");
    @(posedge clk_i);
    stby <= 1'h0;
    dpulse(1, 4'h4);
    chk(loc, 4'h1, "released");
    dpulse(5, 4'h1);
    chk(pwr, 1'h1, "panel on");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h7);
    dpulse(0, 4'h2);
    n = 0;
    while (tmo !== 1'h1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    chk({tmo, loc, pwr}, 6'h23, "timeout keeps power");
    wb(1'h1, `RCA_ADDR_CTRL, 32'h9);
    dpulse(0, 4'h2);
    chk(err, 4'h2, "slave refuses other");
    dpulse(0, 4'h8);
    chk({grant, own}, 6'h23, "slave bus takes over");
    dpulse(1, 4'h8);
    $display("test power done");
    test_done();
  end
endmodule

`default_nettype wire

/* design/rca_arbiter.sv */
// What this block does
// - grant control to analog or one digital interface, never both.
// - refuse digital request with error while analog select is low, unless a digital interface already holds control.
// - ignore analog select changes while a digital interface holds control.
// - status queries always answered, whatever the control location.
// - no owner and no lock means manual, takeover from any interface; in slave mode only the master bus, or usb if allowed.
// - allow-remote flag cleared forces the local, manual-only state.
// - local ends digital session for good; remote must request again.
// - local only suspends analog control while it lasts.
// - leaving local restores analog if select still low, else manual.
// - supervision timer runs only under digital remote control.
// - each message from the owner restarts the full timeout.
// - timeout expiry leaves remote control for manual.
// - on expiry the power input goes off or stays, per configuration.
// - new timeout value takes effect after the running period elapses.
// - supervision timer is independent of the network connection timeout.
// - panel off request always switches the power input off.
// - slave unit takes control from master bus; own usb only by exception.
// - analog select low requests remote, high or open requests manual.
// - standby input acts on the power input in every location.
`timescale 1ns/10ps
`default_nettype none
`include "rca_consts.svh"

module rca_arbiter #(
  parameter int NUM_IF    = 4,
  parameter int IF_W      = 2,
  parameter int MS_IF     = 3,
  parameter int USB_IF    = 0,
  parameter int TMO_W     = 16,
  parameter int MS_CYCLES = `RCA_MS_CYCLES
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // analog interface and panel
  input  wire logic              remote_sel_n_i,
  input  wire logic              analog_dc_on_i,
  input  wire logic              standby_input_i,
  input  wire logic              panel_on_i,
  input  wire logic              panel_off_i,
  // digital interfaces
  input  wire logic [NUM_IF-1:0] dig_req_i,
  input  wire logic [NUM_IF-1:0] dig_rel_i,
  input  wire logic [NUM_IF-1:0] dig_msg_i,
  input  wire logic [NUM_IF-1:0] dig_dc_on_i,
  input  wire logic [NUM_IF-1:0] dig_dc_off_i,
  input  wire logic [NUM_IF-1:0] dig_query_i,
  output logic      [NUM_IF-1:0] dig_grant_o,
  output logic      [NUM_IF-1:0] dig_err_o,
  output logic      [NUM_IF-1:0] dig_query_ack_o,
  // location and power state
  output logic      [3:0]        location_o,
  output logic      [IF_W-1:0]   owner_o,
  output logic                   power_input_en_o,
  output logic                   sup_timeout_o
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [NUM_IF-1:0] one_hot(input logic [IF_W-1:0] idx);
    logic [NUM_IF-1:0] v;
    v      = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  function automatic logic bit_at(input logic [NUM_IF-1:0] vec,
                                  input logic [IF_W-1:0]   idx);
    return vec[idx];
  endfunction

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  rca_pkg::rca_loc_type    state_reg,   state_next;
  logic [IF_W-1:0]         owner_reg,   owner_next;
  logic [NUM_IF-1:0]       grant_reg,   grant_next;
  logic [NUM_IF-1:0]       err_reg,     err_next;
  logic [NUM_IF-1:0]       qack_reg,    qack_next;
  logic                    pwr_reg,     pwr_next;
  logic                    tmo_reg,     tmo_next;
  logic                    evt_reg,     evt_next;
  logic [`RCA_CTRL_W-1:0]  ctrl_reg,    ctrl_next;
  logic                    ack_reg,     ack_next;
  logic [31:0]             dat_reg,     dat_next;
  logic [TMO_W-1:0]        tmo_wval;
  logic                    tmo_we;
  logic [NUM_IF-1:0]       eligible;
  logic                    pick_v;
  logic [IF_W-1:0]         pick_idx;
  logic                    sup_run;
  logic                    sup_kick;
  logic                    sup_expire;
  logic [TMO_W-1:0]        sup_active;
  logic                    tmo_exit;
  logic                    allow;
  logic                    wr_hit;

  assign allow = ctrl_reg[`RCA_CTRL_ALLOW];

  // ---------------------------------------------------------------------------
  // request eligibility and selection
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_IF; i++) begin
      eligible[i] = !ctrl_reg[`RCA_CTRL_SLAVE] || (i == MS_IF) ||
                    ((i == USB_IF) && ctrl_reg[`RCA_CTRL_SLV_USB]);
    end
  end

  rca_req_pick #(
    .NUM_IF (NUM_IF),
    .IF_W   (IF_W)
  ) u_pick (
    .req_i      (dig_req_i),
    .eligible_i (eligible),
    .pick_v_o   (pick_v),
    .pick_idx_o (pick_idx)
  );

  // ---------------------------------------------------------------------------
  // supervision timer, separate from any network connection timeout
  // ---------------------------------------------------------------------------
  assign sup_run  = (state_reg == rca_pkg::RCA_ST_DIGITAL) &&
                    ctrl_reg[`RCA_CTRL_SUP_EN];
  assign sup_kick = bit_at(dig_msg_i, owner_reg);
  assign tmo_exit = sup_run && sup_expire && allow;

  rca_sup_timer #(
    .MS_CYCLES (MS_CYCLES),
    .TMO_W     (TMO_W)
  ) u_sup (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (sup_run),
    .kick_i    (sup_kick),
    .new_val_i (tmo_wval),
    .new_we_i  (tmo_we),
    .expire_o  (sup_expire),
    .active_o  (sup_active)
  );

  // ---------------------------------------------------------------------------
  // control location state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    owner_next = owner_reg;
    grant_next = '0;
    unique case (state_reg)
      rca_pkg::RCA_ST_MANUAL: begin
        if (!allow) begin
          state_next = rca_pkg::RCA_ST_LOCAL;
        end else if (!remote_sel_n_i) begin
          state_next = rca_pkg::RCA_ST_ANALOG;
        end else if (pick_v) begin
          state_next = rca_pkg::RCA_ST_DIGITAL;
          owner_next = pick_idx;
          grant_next = one_hot(pick_idx);
        end
      end
      rca_pkg::RCA_ST_ANALOG: begin
        if (!allow) begin
          state_next = rca_pkg::RCA_ST_LOCAL;
        end else if (remote_sel_n_i) begin
          state_next = rca_pkg::RCA_ST_MANUAL;
        end
      end
      rca_pkg::RCA_ST_DIGITAL: begin
        // analog select not looked at here
        if (!allow) begin
          state_next = rca_pkg::RCA_ST_LOCAL;
        end else if (bit_at(dig_rel_i, owner_reg) || tmo_exit) begin
          state_next = rca_pkg::RCA_ST_MANUAL;
        end else if (bit_at(dig_req_i, owner_reg)) begin
          grant_next = one_hot(owner_reg);
        end
      end
      rca_pkg::RCA_ST_LOCAL: begin
        if (allow) begin
          state_next = remote_sel_n_i ? rca_pkg::RCA_ST_MANUAL
                                      : rca_pkg::RCA_ST_ANALOG;
        end
      end
    endcase
    // every request not granted is refused
    err_next  = dig_req_i & ~grant_next;
    qack_next = dig_query_i;
  end

  // ---------------------------------------------------------------------------
  // power input control
  // ---------------------------------------------------------------------------
  always_comb begin
    pwr_next = pwr_reg;
    unique case (state_reg)
      rca_pkg::RCA_ST_MANUAL,
      rca_pkg::RCA_ST_LOCAL: begin
        if (panel_on_i) begin
          pwr_next = 1'b1;
        end
      end
      rca_pkg::RCA_ST_ANALOG: begin
        pwr_next = analog_dc_on_i;
      end
      rca_pkg::RCA_ST_DIGITAL: begin
        if (bit_at(dig_dc_on_i, owner_reg)) begin
          pwr_next = 1'b1;
        end
        if (bit_at(dig_dc_off_i, owner_reg)) begin
          pwr_next = 1'b0;
        end
      end
    endcase
    if (tmo_exit && !ctrl_reg[`RCA_CTRL_KEEP_ON]) begin
      pwr_next = 1'b0;
    end
    if (panel_off_i) begin
      pwr_next = 1'b0;
    end
    if (standby_input_i) begin
      pwr_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // state, power and event registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= rca_pkg::RCA_ST_MANUAL;
      owner_reg <= '0;
      grant_reg <= '0;
      err_reg   <= '0;
      qack_reg  <= '0;
      pwr_reg   <= 1'b0;
      tmo_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      owner_reg <= owner_next;
      grant_reg <= grant_next;
      err_reg   <= err_next;
      qack_reg  <= qack_next;
      pwr_reg   <= pwr_next;
      tmo_reg   <= tmo_exit;
    end
  end

  // ---------------------------------------------------------------------------
  // wishbone register access
  // ---------------------------------------------------------------------------
  // write lands at the edge where the master samples ack high
  assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign tmo_we   = wr_hit && (wb_adr_i == `RCA_ADDR_TMO) && (wb_sel_i[1:0] == 2'h3);
  assign tmo_wval = wb_dat_i[TMO_W-1:0];

  always_comb begin
    ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
    ctrl_next = ctrl_reg;
    evt_next  = evt_reg;
    dat_next  = '0;
    // write-one clears the sticky timeout flag, a new event wins
    if (wr_hit && (wb_adr_i == `RCA_ADDR_STAT) && wb_sel_i[1] &&
        wb_dat_i[`RCA_STAT_TMO_EVT]) begin
      evt_next = 1'b0;
    end
    if (tmo_exit) begin
      evt_next = 1'b1;
    end
    if (wr_hit && (wb_adr_i == `RCA_ADDR_CTRL) && wb_sel_i[0]) begin
      ctrl_next = wb_dat_i[`RCA_CTRL_W-1:0];
    end
    unique case (wb_adr_i)
      `RCA_ADDR_CTRL: begin
        dat_next[`RCA_CTRL_W-1:0] = ctrl_reg;
      end
      `RCA_ADDR_CUR: begin
        dat_next[TMO_W-1:0] = sup_active;
      end
      `RCA_ADDR_STAT: begin
        dat_next[`RCA_STAT_LOC_LSB +: 4]    = state_reg;
        dat_next[`RCA_STAT_OWN_LSB +: IF_W] = owner_reg;
        dat_next[`RCA_STAT_PWR]             = pwr_reg;
        dat_next[`RCA_STAT_ANA_SEL]         = !remote_sel_n_i;
        dat_next[`RCA_STAT_SUP_RUN]         = sup_run;
        dat_next[`RCA_STAT_TMO_EVT]         = evt_reg;
      end
      default: begin
        dat_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      dat_reg  <= '0;
      ctrl_reg <= `RCA_CTRL_RST;
      evt_reg  <= 1'b0;
    end else begin
      ack_reg  <= ack_next;
      dat_reg  <= dat_next;
      ctrl_reg <= ctrl_next;
      evt_reg  <= evt_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = dat_reg;
  assign dig_grant_o      = grant_reg;
  assign dig_err_o        = err_reg;
  assign dig_query_ack_o  = qack_reg;
  assign location_o       = state_reg;
  assign owner_o          = owner_reg;
  assign power_input_en_o = pwr_reg;
  assign sup_timeout_o    = tmo_reg;

endmodule

`default_nettype wire

/* design/rca_consts.svh */
`ifndef RCA_CONSTS_SVH
`define RCA_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RCA_ADDR_CTRL      8'h00
`define RCA_ADDR_TMO       8'h04
`define RCA_ADDR_STAT      8'h08
`define RCA_ADDR_CUR       8'h0C

// ----------------------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------------------
`define RCA_CTRL_ALLOW     0
`define RCA_CTRL_SUP_EN    1
`define RCA_CTRL_KEEP_ON   2
`define RCA_CTRL_SLAVE     3
`define RCA_CTRL_SLV_USB   4
`define RCA_CTRL_W         5
`define RCA_CTRL_RST       5'h03

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define RCA_STAT_LOC_LSB   0
`define RCA_STAT_OWN_LSB   4
`define RCA_STAT_PWR       8
`define RCA_STAT_ANA_SEL   9
`define RCA_STAT_SUP_RUN   10
`define RCA_STAT_TMO_EVT   11

// ----------------------------------------------------------------------------
// supervision timing
// ----------------------------------------------------------------------------
`define RCA_TMO_RST        16'h03E8
`define RCA_CLK_NS         100
`define RCA_MS_NS          1000000
`define RCA_MS_CYCLES      (`RCA_MS_NS / `RCA_CLK_NS)

`endif

/* design/rca_pkg.sv */
package rca_pkg;

  // control location, one-hot
  typedef enum logic [3:0] {
    RCA_ST_MANUAL  = 4'h1,
    RCA_ST_ANALOG  = 4'h2,
    RCA_ST_DIGITAL = 4'h4,
    RCA_ST_LOCAL   = 4'h8
  } rca_loc_type;

endpackage

/* design/rca_req_pick.sv */
`timescale 1ns/10ps
`default_nettype none

module rca_req_pick #(
  parameter int NUM_IF = 4,
  parameter int IF_W   = 2
) (
  // requests and eligibility
  input  wire logic [NUM_IF-1:0] req_i,
  input  wire logic [NUM_IF-1:0] eligible_i,
  // chosen request
  output logic                   pick_v_o,
  output logic [IF_W-1:0]        pick_idx_o
);

  // ---------------------------------------------------------------------------
  // lowest eligible index wins
  // ---------------------------------------------------------------------------
  always_comb begin
    pick_v_o   = 1'b0;
    pick_idx_o = '0;
    for (int i = NUM_IF - 1; i >= 0; i--) begin
      if (req_i[i] && eligible_i[i]) begin
        pick_v_o   = 1'b1;
        pick_idx_o = IF_W'(i);
      end
    end
  end

endmodule

`default_nettype wire

/* design/rca_sup_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rca_consts.svh"

module rca_sup_timer #(
  parameter int MS_CYCLES = `RCA_MS_CYCLES,
  parameter int TMO_W     = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             run_i,
  input  wire logic             kick_i,
  input  wire logic [TMO_W-1:0] new_val_i,
  input  wire logic             new_we_i,
  // results
  output logic                  expire_o,
  output logic [TMO_W-1:0]      active_o
);

  localparam int PRE_W = $clog2(MS_CYCLES + 1);

  logic [PRE_W-1:0] pre_reg,    pre_next;
  logic [TMO_W-1:0] left_reg,   left_next;
  logic [TMO_W-1:0] act_reg,    act_next;
  logic [TMO_W-1:0] pend_reg,   pend_next;
  logic             pend_v_reg, pend_v_next;
  logic             exp_reg,    exp_next;
  logic [TMO_W-1:0] eff_val;
  logic             eff_v;

  // ---------------------------------------------------------------------------
  // millisecond prescaler and timeout count
  // ---------------------------------------------------------------------------
  always_comb begin
    eff_val     = new_we_i ? new_val_i : pend_reg;
    eff_v       = new_we_i | pend_v_reg;
    pre_next    = pre_reg;
    left_next   = left_reg;
    act_next    = act_reg;
    pend_next   = eff_val;
    pend_v_next = eff_v;
    exp_next    = 1'b0;
    if (!run_i) begin
      // idle: no period running, a pending value applies at once
      pre_next    = '0;
      act_next    = eff_v ? eff_val : act_reg;
      left_next   = act_next;
      pend_v_next = 1'b0;
    end else if (kick_i) begin
      pre_next  = '0;
      left_next = act_reg;
    end else if (pre_reg == PRE_W'(MS_CYCLES - 1)) begin
      pre_next = '0;
      if (left_reg <= TMO_W'(1)) begin
        exp_next    = 1'b1;
        act_next    = eff_v ? eff_val : act_reg;
        left_next   = act_next;
        pend_v_next = 1'b0;
      end else begin
        left_next = left_reg - TMO_W'(1);
      end
    end else begin
      pre_next = pre_reg + PRE_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg    <= '0;
      left_reg   <= `RCA_TMO_RST;
      act_reg    <= `RCA_TMO_RST;
      pend_reg   <= '0;
      pend_v_reg <= 1'b0;
      exp_reg    <= 1'b0;
    end else begin
      pre_reg    <= pre_next;
      left_reg   <= left_next;
      act_reg    <= act_next;
      pend_reg   <= pend_next;
      pend_v_reg <= pend_v_next;
      exp_reg    <= exp_next;
    end
  end

  assign expire_o = exp_reg;
  assign active_o = act_reg;

endmodule

`default_nettype wire
